// ===== dv/evt_peer.sv
// Event bus peer: free link clock, frame sender and frame receiver.
// Assumes an open-drain line with pull-up; bits move on falling clock.
`timescale 1ns/100ps
module evt_peer (
	input  wire logic i_line, // Resolved bus level
	output logic      o_clk,  // Link clock
	output logic      o_oe    // High while pulling low
);
	logic [8:0] rxq[$];
	logic       busy = 1'b0;
	initial o_clk = 1'b0;
	initial o_oe = 1'b0;
	// The device may start a frame at any time, so the clock runs free
	always #62.5 o_clk = ~o_clk;
	// Collect device frames: start bit, then kind and address MSB first
	initial forever begin : rx
		logic [8:0] f;
		@(posedge o_clk);
		if (!busy && i_line === 1'b0) begin
			for (int i = 8; i >= 0; i--) begin
				@(posedge o_clk);
				f[i] = i_line;
			end
			rxq.push_back(f);
		end
	end
	// Send one frame, releasing the line after the last bit
	task automatic send(input logic [8:0] f);
		busy = 1'b1;
		@(negedge o_clk) o_oe <= 1'b1;
		for (int i = 8; i >= 0; i--) @(negedge o_clk) o_oe <= !f[i];
		@(negedge o_clk) o_oe <= 1'b0;
		busy = 1'b0;
	endtask
endmodule

// ===== dv/power_sequencing_fault_capture_tb_top.sv
// Self-checking bench: straps, phase, sequencing, faults and capture.
// Assumes the hand-over bus timing; store times shortened to 20 and 40.
`timescale 1ns/100ps
module power_sequencing_fault_capture_tb_top;
	logic         clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, en = 0, flt = 0;
	logic [7:0]   adr = 0;
	logic [31:0]  wd = 0, rd, q;
	logic [4:0]   cfg = 0, ph;
	logic [5:0]   sa = 0;
	logic [175:0] live = 0;
	logic [1:0]   sdir;
	logic         ack, oe, alert_n, pwr, trk, peer_oe, eclk;
	int           miscompares = 0, samples_checked = 0, p, s;
	wire          line = !(oe | peer_oe);
	// Clock at 250 MHz
	always #2 clk = ~clk;
	pwrseq_top #(.NVM_SHORT_CYC(20), .NVM_LONG_CYC(40)) pwrseq_top_i (
		.i_sys_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wd), .o_wb_dat(rd),
		.o_wb_ack(ack), .i_cfg_strap(cfg), .i_addr_strap(sa), .i_enable(en), .i_fault(flt),
		.i_live_params(live), .i_evt_clk(eclk), .i_evt_bus_in(line), .o_evt_bus_out(),
		.o_evt_bus_oe(oe), .o_fault_alert_n(alert_n), .o_power_en(pwr), .o_phase_step(ph),
		.o_sync_dir(sdir), .o_track_en(trk));
	evt_peer evt_peer_i (.i_line(line), .o_clk(eclk), .o_oe(peer_oe));
	// Comparison, verdict and bounded waits
	task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
		samples_checked++;
		if (v !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n == 50) begin
			miscompares++;
			final_report();
		end
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wpwr(input logic v);
		int n;
		for (n = 0; n < 3000 && pwr !== v; n++) @(posedge clk);
		chk("power_en", pwr, v);
		if (n == 3000) final_report();
	endtask
	task automatic wfrm(input logic [1:0] k, input logic [6:0] a);
		int n;
		for (n = 0; n < 3000 && evt_peer_i.rxq.size() == 0; n++) @(posedge clk);
		if (n == 3000) begin
			miscompares++;
			final_report();
		end
		chk("event", evt_peer_i.rxq.pop_front(), {k, a});
	endtask
	task automatic rst_to(input logic [4:0] c, input logic [5:0] a);
		@(posedge clk);
		cfg <= c;
		sa <= a;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	function automatic logic [6:0] addr_of(input int a);
		return (a < 3) ? 7'(32 + a) : 7'(29 + a);
	endfunction
	initial begin
		q = $urandom(32'hd2ba952d);
		// Strap decode for every sequence strap code
		for (int c = 0; c < 18; c++) begin
			rst_to(5'(c), 6'h00);
			wb(0, pwrseq_pkg::OFS_STATUS, 0);
			chk("sync_dir", sdir, c % 3);
			chk("track_en", trk, c / 3 == 5);
			chk("role", q[5:4], c/3 == 2 ? 1 : c/3 == 3 ? 3 : c/3 == 4 ? 2 : 0);
		end
		// Address strap and address-derived phase
		for (int i = 0; i < 10; i++) begin
			s = (i < 3) ? i : (i == 3) ? 32 : $urandom_range(31, 3);
			rst_to(5'h00, 6'(s));
			wb(0, pwrseq_pkg::OFS_STATUS, 0);
			chk("addr", q[14:8], addr_of(s));
			chk("phase", ph, addr_of(s) % 8 * 2);
		end
		// Commanded phase, ignored in autonomous mode
		for (int c = 0; c < 13; c += 12) begin
			rst_to(5'(c), 6'h02);
			p = c ? $urandom_range(15) : 16;
			wb(1, pwrseq_pkg::OFS_CTRL, 32'h05);
			wb(1, pwrseq_pkg::OFS_PHASE, p);
			repeat (3) @(posedge clk);
			chk("cmd_phase", ph, c ? 4 : p);
		end
		// Middle device waits for its neighbours on the event bus
		rst_to(5'd12, 6'h01);
		en <= 1'b1;
		repeat (600) @(posedge clk);
		chk("power_en", pwr, 0);
		evt_peer_i.send({2'h0, 7'h20});
		wpwr(1);
		wfrm(0, 7'h21);
		@(posedge clk);
		en <= 1'b0;
		repeat (600) @(posedge clk);
		chk("power_en", pwr, 1);
		evt_peer_i.send({2'h1, 7'h22});
		wpwr(0);
		wfrm(1, 7'h21);
		// First device: capture read, local fault, alert and store
		rst_to(5'd6, 6'h00);
		wb(1, pwrseq_pkg::OFS_MISC, 32'h2);
		for (int i = 0; i < 22; i++) live[i*8 +: 8] <= 8'($urandom);
		en <= 1'b1;
		wpwr(1);
		wfrm(0, 7'h20);
		wb(1, pwrseq_pkg::OFS_CAPPTR, 0);
		for (int i = 0; i < 22; i++) begin
			wb(0, pwrseq_pkg::OFS_CAPDAT, 0);
			chk("cap_byte", q[7:0], live[i*8 +: 8]);
		end
		flt <= 1'b1;
		wpwr(0);
		chk("alert_n", alert_n, 0);
		wb(0, pwrseq_pkg::OFS_STATUS, 0);
		chk("store_busy", q[24], 1);
		repeat (30) @(posedge clk);
		wb(0, pwrseq_pkg::OFS_STATUS, 0);
		chk("store_busy", q[24], 0);
		wfrm(2, 7'h20);
		flt <= 1'b0;
		repeat (4) @(posedge clk);
		wb(1, pwrseq_pkg::OFS_FAULT, 32'h1);
		@(posedge clk);
		chk("alert_n", alert_n, 1);
		wb(1, pwrseq_pkg::OFS_CAPCMD, 32'h2);
		wb(0, pwrseq_pkg::OFS_STATUS, 0);
		chk("store_busy", q[24], 0);
		en <= 1'b0;
		repeat (3) @(posedge clk);
		wb(1, pwrseq_pkg::OFS_CAPCMD, 32'h2);
		wb(0, pwrseq_pkg::OFS_STATUS, 0);
		chk("store_busy", q[24], 1);
		// Peer fault: follow into shutdown, then restart in order
		rst_to(5'd6, 6'h00);
		wb(1, pwrseq_pkg::OFS_CTRL, 32'h1c);
		en <= 1'b1;
		wpwr(1);
		wfrm(0, 7'h20);
		// The restart follows within a cycle, so watch power while the frame goes out
		fork
			evt_peer_i.send({2'h2, 7'h21});
			wpwr(0);
		join
		wpwr(1);
		wfrm(0, 7'h20);
		final_report();
	end
endmodule

// ===== hw/pwrseq_top.sv
// Power sequencing, phase selection, fault spreading, alert and capture store.
// Assumes straps, enable, fault and event bus lines are asynchronous pins and
// a classic Wishbone master on the system clock.
//
// Operation
// - Address-derived offset: 0 to 315 degrees in 45 degree steps
// - Accept commanded offset in 22.5 degree steps
// - Autonomous mode sequences via event bus events
// - Autonomous mode forces address-derived phase offset
// - Sequence strap decodes sync pin direction
// - First two strap triples (codes 0 to 5) disable sequencing, tracking
// - Strap groups select first, last, middle role
// - Top strap group disables sequencing, enables tracking
// - Turn-on ascends from lowest address
// - Turn-off descends from highest address
// - Predecessor/successor commands allow free addressing
// - Enable rise starts on from ST_OFF, turns off from ST_WAIT_OFF; fall starts off
// - Shutdown fault in ST_ON shuts down and broadcasts event
// - Peer fault event in ST_ON: shutdown, optional ordered restart
// - Alert line low while any sticky fault flag is set, until cleared by write-one
// - Capture enabled only by misc bit 1
// - Capture read as 22-byte block anytime
// - Fault capture stored only for shutdown response
// - Capture store takes 700 or 1400 us
// - Command 1 loads store, 2 stores when disabled
// - Default phase is address times 45 degrees
// - Address strap low/open/high gives 0x20/21/22
`timescale 1ns/100ps
module pwrseq_top #(
	parameter int unsigned NVM_SHORT_CYC = pwrseq_pkg::NVM_SHORT_CYC, // Short store time
	parameter int unsigned NVM_LONG_CYC  = pwrseq_pkg::NVM_LONG_CYC   // Block store time
) (
	input  wire logic         i_sys_clk,       // System clock, 250 MHz
	input  wire logic         i_sys_rst,       // Synchronous reset, active high
	input  wire logic         i_ce,            // Clock enable, freezes state when low
	input  wire logic         i_wb_cyc,        // Wishbone cycle
	input  wire logic         i_wb_stb,        // Wishbone strobe
	input  wire logic         i_wb_we,         // Wishbone write enable
	input  wire logic [7:0]   i_wb_adr,        // Wishbone byte address
	input  wire logic [3:0]   i_wb_sel,        // Wishbone byte selects
	input  wire logic [31:0]  i_wb_dat,        // Wishbone write data
	output logic [31:0]       o_wb_dat,        // Wishbone read data
	output logic              o_wb_ack,        // Wishbone acknowledge
	input  wire logic [4:0]   i_cfg_strap,     // Sequence strap code 0..17
	input  wire logic [5:0]   i_addr_strap,    // Address strap code 0..32
	input  wire logic         i_enable,        // Group enable pin
	input  wire logic         i_fault,         // Local fault detected
	input  wire logic [175:0] i_live_params,   // Live parameters, 22 bytes
	input  wire logic         i_evt_clk,       // Event bus clock
	input  wire logic         i_evt_bus_in,    // Event bus line level
	output logic              o_evt_bus_out,   // Event bus drive value, always 0
	output logic              o_evt_bus_oe,    // Event bus pull-down enable
	output logic              o_fault_alert_n, // Fault alert line, active low
	output logic              o_power_en,      // Power stage enable
	output logic [4:0]        o_phase_step,    // Phase offset in 22.5 degree steps
	output logic [1:0]        o_sync_dir,      // Sync pin direction
	output logic              o_track_en       // Voltage tracking enable
);
	typedef enum logic [1:0] {ST_OFF, ST_WAIT_ON, ST_ON, ST_WAIT_OFF} seq_state_t;

	// Decode of the sequence strap into the configuration carrier
	function automatic pwrseq_pkg::strap_cfg_t decode_cfg(input logic [4:0] code);
		pwrseq_pkg::strap_cfg_t c;
		logic [2:0] grp;
		grp        = 3'(code / 5'h03);
		c.sync_dir = pwrseq_pkg::sync_dir_t'(2'(code % 5'h03));
		c.track_en = (grp == pwrseq_pkg::GRP_TRACK);
		unique case (grp)
			pwrseq_pkg::GRP_FIRST: c.role = pwrseq_pkg::ROLE_FIRST;
			pwrseq_pkg::GRP_LAST:  c.role = pwrseq_pkg::ROLE_LAST;
			pwrseq_pkg::GRP_MID:   c.role = pwrseq_pkg::ROLE_MID;
			default:               c.role = pwrseq_pkg::ROLE_NONE;
		endcase
		return c;
	endfunction

	// Two-stage synchronisers for all pins
	logic [4:0]  cfg_s1, cfg_s2;
	logic [5:0]  adr_s1, adr_s2;
	logic [3:0]  pin_s1, pin_s2;
	logic        en_d, evt_clk_d;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cfg_s1 <= 5'h00;
			cfg_s2 <= 5'h00;
			adr_s1 <= 6'h00;
			adr_s2 <= 6'h00;
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end else if (i_ce) begin
			cfg_s1 <= i_cfg_strap;
			cfg_s2 <= cfg_s1;
			adr_s1 <= i_addr_strap;
			adr_s2 <= adr_s1;
			pin_s1 <= {i_enable, i_fault, i_evt_clk, i_evt_bus_in};
			pin_s2 <= pin_s1;
		end
	end
	wire logic en_sync   = pin_s2[3];
	wire logic fault_sync = pin_s2[2];
	wire logic evt_clk_s = pin_s2[1];
	wire logic evt_dat_s = pin_s2[0];

	// Straps are caught once after reset release
	pwrseq_pkg::strap_cfg_t cfg_reg;
	logic [6:0]  my_addr_reg;
	logic [1:0]  strap_wait_reg;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cfg_reg        <= '0;
			my_addr_reg    <= 7'h00;
			strap_wait_reg <= 2'h0;
		end else if (i_ce && strap_wait_reg != 2'h3) begin
			strap_wait_reg <= strap_wait_reg + 2'h1;
			if (strap_wait_reg == 2'h2) begin
				cfg_reg <= decode_cfg(cfg_s2);
				if (adr_s2 < pwrseq_pkg::ADDR_STRAP_RES)
					my_addr_reg <= pwrseq_pkg::ADDR_BASE + 7'(adr_s2);
				else
					my_addr_reg <= pwrseq_pkg::ADDR_BASE + 7'(adr_s2 - pwrseq_pkg::ADDR_STRAP_RES);
			end
		end
	end
	wire logic strap_done = (strap_wait_reg == 2'h3);

	// Software registers
	logic [pwrseq_pkg::CTRL_W-1:0] ctrl_reg;
	logic [4:0]  phase_cmd_reg;
	logic [6:0]  pred_reg, succ_reg;
	logic [7:0]  misc_reg;
	logic [1:0]  fault_flags_reg;
	logic        ack_reg;
	wire logic   wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
	wire logic   wb_wr  = wb_req && i_wb_we && i_wb_sel[0];
	wire logic   wb_rd  = wb_req && !i_wb_we;

	// Control writes
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ctrl_reg      <= pwrseq_pkg::CTRL_RST;
			phase_cmd_reg <= 5'h00;
			pred_reg      <= 7'h00;
			succ_reg      <= 7'h00;
			misc_reg      <= 8'h00;
		end else if (i_ce && wb_wr) begin
			unique case (i_wb_adr)
				pwrseq_pkg::OFS_CTRL:  ctrl_reg <= i_wb_dat[pwrseq_pkg::CTRL_W-1:0];
				pwrseq_pkg::OFS_PHASE: phase_cmd_reg <= (i_wb_dat[4:0] > pwrseq_pkg::PHASE_MAX)
					? pwrseq_pkg::PHASE_MAX : i_wb_dat[4:0];
				pwrseq_pkg::OFS_PRED:  pred_reg <= i_wb_dat[6:0];
				pwrseq_pkg::OFS_SUCC:  succ_reg <= i_wb_dat[6:0];
				pwrseq_pkg::OFS_MISC:  misc_reg <= i_wb_dat[7:0];
				default: ;
			endcase
		end
	end

	// Sequencing mode, neighbours and phase selection
	wire logic autonomous = (cfg_reg.role != pwrseq_pkg::ROLE_NONE) && !ctrl_reg[pwrseq_pkg::CTRL_CMD_SEQ];
	wire logic seq_active = autonomous || ctrl_reg[pwrseq_pkg::CTRL_CMD_SEQ];
	wire logic [6:0] pred_addr = autonomous ? my_addr_reg - 7'h01 : pred_reg;
	wire logic [6:0] succ_addr = autonomous ? my_addr_reg + 7'h01 : succ_reg;
	wire logic is_first = autonomous ? cfg_reg.role == pwrseq_pkg::ROLE_FIRST : pred_reg == my_addr_reg;
	wire logic is_last  = autonomous ? cfg_reg.role == pwrseq_pkg::ROLE_LAST : succ_reg == my_addr_reg;
	wire logic [4:0] addr_phase = 5'(my_addr_reg[2:0]) * pwrseq_pkg::PHASE_PER_ADDR;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst)
			o_phase_step <= 5'h00;
		else if (i_ce)
			o_phase_step <= (ctrl_reg[pwrseq_pkg::CTRL_PHASE_CMD] && !autonomous)
				? phase_cmd_reg : addr_phase;
	end
	assign o_sync_dir = cfg_reg.sync_dir;
	assign o_track_en = cfg_reg.track_en && !seq_active;

	// Event bus receiver: sampled on event clock rising edges
	logic        rx_busy_reg, rx_stb_reg;
	logic [3:0]  rx_cnt_reg;
	logic [8:0]  rx_sh_reg;
	pwrseq_pkg::evt_t rx_evt_reg;
	wire logic   evt_rise = evt_clk_s && !evt_clk_d;
	wire logic   evt_fall = !evt_clk_s && evt_clk_d;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			evt_clk_d   <= 1'b0;
			rx_busy_reg <= 1'b0;
			rx_stb_reg  <= 1'b0;
			rx_cnt_reg  <= 4'h0;
			rx_sh_reg   <= 9'h000;
			rx_evt_reg  <= '0;
		end else if (i_ce) begin
			evt_clk_d  <= evt_clk_s;
			rx_stb_reg <= 1'b0;
			if (evt_rise) begin
				if (!rx_busy_reg && !evt_dat_s) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg  <= 4'h0;
				end else if (rx_busy_reg) begin
					rx_sh_reg  <= {rx_sh_reg[7:0], evt_dat_s};
					rx_cnt_reg <= rx_cnt_reg + 4'h1;
					if (rx_cnt_reg == 4'(pwrseq_pkg::EVT_BITS - 1)) begin
						rx_busy_reg <= 1'b0;
						rx_stb_reg  <= 1'b1;
						rx_evt_reg  <= {rx_sh_reg[7:0], evt_dat_s};
					end
				end
			end
		end
	end
	wire logic rx_on    = rx_stb_reg && rx_evt_reg.kind == pwrseq_pkg::EVT_ON  && rx_evt_reg.addr == pred_addr;
	wire logic rx_off   = rx_stb_reg && rx_evt_reg.kind == pwrseq_pkg::EVT_OFF && rx_evt_reg.addr == succ_addr;
	wire logic rx_fault = rx_stb_reg && rx_evt_reg.kind == pwrseq_pkg::EVT_FAULT
		&& rx_evt_reg.addr != my_addr_reg; // Own frame heard back is not a peer fault

	// Sequencer state machine
	seq_state_t  state_reg;
	logic        tx_req_reg, restart_reg;
	pwrseq_pkg::evt_kind_t tx_kind_reg;
	logic        tx_take;
	wire logic   en_rise  = en_sync && !en_d;
	wire logic   en_fall  = !en_sync && en_d;
	wire logic   loc_fault = fault_sync && ctrl_reg[pwrseq_pkg::CTRL_SHUTDOWN];
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_reg   <= ST_OFF;
			en_d        <= 1'b0;
			tx_req_reg  <= 1'b0;
			tx_kind_reg <= pwrseq_pkg::EVT_ON;
			restart_reg <= 1'b0;
		end else if (i_ce && strap_done) begin
			en_d <= en_sync;
			if (tx_take)
				tx_req_reg <= 1'b0;
			unique case (state_reg)
				ST_OFF: if (en_rise || (restart_reg && en_sync)) begin
					restart_reg <= 1'b0;
					if (seq_active && !is_first)
						state_reg <= ST_WAIT_ON;
					else begin
						state_reg   <= ST_ON;
						tx_req_reg  <= seq_active;
						tx_kind_reg <= pwrseq_pkg::EVT_ON;
					end
				end
				ST_WAIT_ON: if (!en_sync)
					state_reg <= ST_OFF;
				else if (rx_on) begin
					state_reg   <= ST_ON;
					tx_req_reg  <= 1'b1;
					tx_kind_reg <= pwrseq_pkg::EVT_ON;
				end
				ST_ON: if (loc_fault) begin
					state_reg   <= ST_OFF;
					tx_req_reg  <= 1'b1;
					tx_kind_reg <= pwrseq_pkg::EVT_FAULT;
				end else if (rx_fault && ctrl_reg[pwrseq_pkg::CTRL_FOLLOW]) begin
					state_reg   <= ST_OFF;
					restart_reg <= ctrl_reg[pwrseq_pkg::CTRL_RESTART];
				end else if (en_fall) begin
					if (seq_active && !is_last)
						state_reg <= ST_WAIT_OFF;
					else begin
						state_reg   <= ST_OFF;
						tx_req_reg  <= seq_active;
						tx_kind_reg <= pwrseq_pkg::EVT_OFF;
					end
				end
				ST_WAIT_OFF: if (rx_off || en_rise) begin
					state_reg   <= ST_OFF;
					tx_req_reg  <= 1'b1;
					tx_kind_reg <= pwrseq_pkg::EVT_OFF;
				end
			endcase
		end
	end
	// Output stays up while waiting for the successor to turn off
	assign o_power_en = (state_reg == ST_ON) || (state_reg == ST_WAIT_OFF);

	// Event bus transmitter: bits change on event clock falling edges
	logic        tx_busy_reg;
	logic [3:0]  tx_cnt_reg;
	logic [9:0]  tx_sh_reg;
	assign tx_take = tx_req_reg && !tx_busy_reg && !rx_busy_reg && evt_fall;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			tx_busy_reg  <= 1'b0;
			tx_cnt_reg   <= 4'h0;
			tx_sh_reg    <= 10'h3ff;
			o_evt_bus_oe <= 1'b0;
		end else if (i_ce) begin
			if (tx_take) begin
				tx_busy_reg  <= 1'b1;
				tx_cnt_reg   <= 4'h0;
				tx_sh_reg    <= {1'b0, tx_kind_reg, my_addr_reg};
				o_evt_bus_oe <= 1'b1;
			end else if (tx_busy_reg && evt_fall) begin
				tx_sh_reg    <= {tx_sh_reg[8:0], 1'b1};
				o_evt_bus_oe <= !tx_sh_reg[8] && tx_cnt_reg != 4'(pwrseq_pkg::EVT_BITS);
				tx_cnt_reg   <= tx_cnt_reg + 4'h1;
				if (tx_cnt_reg == 4'(pwrseq_pkg::EVT_BITS))
					tx_busy_reg <= 1'b0;
			end
		end
	end
	assign o_evt_bus_out = 1'b0;

	// Sticky fault flags, set wins over write-one-to-clear
	wire logic [1:0] flt_set = {rx_fault, fault_sync};
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst)
			fault_flags_reg <= 2'h0;
		else if (i_ce) begin
			if (wb_wr && i_wb_adr == pwrseq_pkg::OFS_FAULT)
				fault_flags_reg <= (fault_flags_reg & ~i_wb_dat[1:0]) | flt_set;
			else
				fault_flags_reg <= fault_flags_reg | flt_set;
		end
	end
	assign o_fault_alert_n = !(|fault_flags_reg);

	// Capture RAM, stored copy and store timer
	logic [7:0]  cap_ram [pwrseq_pkg::CAP_BYTES];
	logic [7:0]  cap_nvm [pwrseq_pkg::CAP_BYTES];
	logic [4:0]  cap_ptr_reg;
	logic [pwrseq_pkg::NVM_CNT_W-1:0] nvm_cnt_reg;
	logic        nvm_busy_reg, fault_d;
	wire logic   cap_en   = misc_reg[pwrseq_pkg::MISC_CAP_EN];
	wire logic   fault_cap = cap_en && fault_sync && !fault_d && ctrl_reg[pwrseq_pkg::CTRL_SHUTDOWN];
	wire logic   cmd_wr   = wb_wr && i_wb_adr == pwrseq_pkg::OFS_CAPCMD;
	wire logic   cmd_load = cmd_wr && i_wb_dat[7:0] == pwrseq_pkg::CAPCMD_LOAD;
	wire logic   cmd_store = cmd_wr && i_wb_dat[7:0] == pwrseq_pkg::CAPCMD_STORE
		&& state_reg == ST_OFF && !en_sync;
	wire logic   store_go = (fault_cap || cmd_store) && !nvm_busy_reg;
	wire logic [pwrseq_pkg::NVM_CNT_W-1:0] store_len = ctrl_reg[pwrseq_pkg::CTRL_BLOCK_WR]
		? pwrseq_pkg::NVM_CNT_W'(NVM_LONG_CYC - 1) : pwrseq_pkg::NVM_CNT_W'(NVM_SHORT_CYC - 1);
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			nvm_busy_reg <= 1'b0;
			nvm_cnt_reg  <= '0;
			fault_d      <= 1'b0;
		end else if (i_ce) begin
			fault_d <= fault_sync;
			if (store_go) begin
				nvm_busy_reg <= 1'b1;
				nvm_cnt_reg  <= store_len;
			end else if (nvm_busy_reg) begin
				nvm_cnt_reg <= nvm_cnt_reg - 1'b1;
				if (nvm_cnt_reg == '0)
					nvm_busy_reg <= 1'b0;
			end
		end
	end
	generate
		for (genvar b = 0; b < pwrseq_pkg::CAP_BYTES; b++) begin : g_cap
			// Live capture into RAM, load from store, and commit at store end
			always_ff @(posedge i_sys_clk) begin
				if (i_sys_rst) begin
					cap_ram[b] <= 8'h00;
					cap_nvm[b] <= 8'h00;
				end else if (i_ce) begin
					if (cmd_load && !nvm_busy_reg)
						cap_ram[b] <= cap_nvm[b];
					else if (cap_en && state_reg == ST_ON && !fault_d && !nvm_busy_reg)
						cap_ram[b] <= i_live_params[b*8 +: 8];
					if (nvm_busy_reg && nvm_cnt_reg == '0)
						cap_nvm[b] <= cap_ram[b];
				end
			end
		end
	endgenerate

	// Block-read pointer: each data read advances and wraps at 22 bytes
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst)
			cap_ptr_reg <= 5'h00;
		else if (i_ce) begin
			if (wb_wr && i_wb_adr == pwrseq_pkg::OFS_CAPPTR)
				cap_ptr_reg <= 5'(i_wb_dat[4:0] % 5'(pwrseq_pkg::CAP_BYTES));
			else if (wb_rd && i_wb_adr == pwrseq_pkg::OFS_CAPDAT)
				cap_ptr_reg <= (cap_ptr_reg == 5'(pwrseq_pkg::CAP_BYTES - 1)) ? 5'h00
					: cap_ptr_reg + 5'h01;
		end
	end

	// Wishbone answer one cycle after the request, unmapped reads return zero
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ack_reg  <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else if (i_ce) begin
			ack_reg <= wb_req;
			if (wb_rd) begin
				unique case (i_wb_adr)
					pwrseq_pkg::OFS_CTRL:   o_wb_dat <= 32'(ctrl_reg);
					pwrseq_pkg::OFS_PHASE:  o_wb_dat <= 32'(phase_cmd_reg);
					pwrseq_pkg::OFS_PRED:   o_wb_dat <= 32'(pred_reg);
					pwrseq_pkg::OFS_SUCC:   o_wb_dat <= 32'(succ_reg);
					pwrseq_pkg::OFS_MISC:   o_wb_dat <= 32'(misc_reg);
					pwrseq_pkg::OFS_STATUS: o_wb_dat <= {7'h00, nvm_busy_reg, 3'h0, o_phase_step,
						1'b0, my_addr_reg, 1'b0, o_track_en, cfg_reg.role, o_sync_dir, state_reg};
					pwrseq_pkg::OFS_FAULT:  o_wb_dat <= 32'(fault_flags_reg);
					pwrseq_pkg::OFS_CAPPTR: o_wb_dat <= 32'(cap_ptr_reg);
					pwrseq_pkg::OFS_CAPDAT: o_wb_dat <= 32'(cap_ram[cap_ptr_reg]);
					default:                o_wb_dat <= 32'h00000000;
				endcase
			end
		end
	end
	assign o_wb_ack = ack_reg;

	// Checks
	sequence s_store_started;
		store_go && i_ce;
	endsequence
	a_phase_forced: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		autonomous && i_ce |=> o_phase_step == $past(addr_phase))
		else $error("phase not forced in autonomous mode");
	a_phase_range: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		o_phase_step <= pwrseq_pkg::PHASE_MAX)
		else $error("phase step out of range");
	a_fault_shut: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		state_reg == ST_ON && loc_fault && i_ce && strap_done |=> !o_power_en && tx_req_reg)
		else $error("shutdown fault not handled");
	a_alert_low: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		fault_sync && i_ce |=> !o_fault_alert_n)
		else $error("alert not asserted");
	a_wait_on: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		state_reg == ST_WAIT_ON && en_sync && !rx_on && i_ce |=> !o_power_en)
		else $error("turned on before predecessor");
	a_store_busy: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		s_store_started |=> nvm_busy_reg [*8])
		else $error("store ended early");
	a_no_retry_store: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!ctrl_reg[pwrseq_pkg::CTRL_SHUTDOWN] && !cmd_store && !nvm_busy_reg && i_ce
		|=> !nvm_busy_reg)
		else $error("store on retry fault");
	a_store_off_only: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		cmd_wr && i_wb_dat[7:0] == pwrseq_pkg::CAPCMD_STORE && !fault_cap && !nvm_busy_reg
		&& (state_reg != ST_OFF || en_sync) && i_ce |=> !nvm_busy_reg)
		else $error("store while enabled");
	a_wb_ack: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		wb_req && i_ce |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack timing wrong");
endmodule

// ===== shared/pwrseq_pkg.sv
// Constants, field layouts and carrier types for the power sequencing block.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
package pwrseq_pkg;
	// Clock rate and capture write times
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned NVM_SHORT_US  = 700;
	localparam int unsigned NVM_LONG_US   = 1400;
	localparam int unsigned NVM_SHORT_CYC = NVM_SHORT_US * CLK_MHZ;
	localparam int unsigned NVM_LONG_CYC  = NVM_LONG_US * CLK_MHZ;
	localparam int unsigned NVM_CNT_W     = 19;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PHASE  = 8'h04;
	localparam logic [7:0] OFS_PRED   = 8'h08;
	localparam logic [7:0] OFS_SUCC   = 8'h0c;
	localparam logic [7:0] OFS_MISC   = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_FAULT  = 8'h18;
	localparam logic [7:0] OFS_CAPCMD = 8'h1c;
	localparam logic [7:0] OFS_CAPPTR = 8'h20;
	localparam logic [7:0] OFS_CAPDAT = 8'h24;

	// Control register fields
	localparam int CTRL_PHASE_CMD = 0;
	localparam int CTRL_BLOCK_WR  = 1;
	localparam int CTRL_SHUTDOWN  = 2;
	localparam int CTRL_FOLLOW    = 3;
	localparam int CTRL_RESTART   = 4;
	localparam int CTRL_CMD_SEQ   = 5;
	localparam int CTRL_W         = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h04;
	localparam int MISC_CAP_EN    = 1;

	// Fault flag bits
	localparam int FLT_LOCAL  = 0;
	localparam int FLT_REMOTE = 1;

	// Capture store and commands
	localparam int CAP_BYTES              = 22;
	localparam logic [7:0] CAPCMD_LOAD    = 8'h01;
	localparam logic [7:0] CAPCMD_STORE   = 8'h02;

	// Addresses and phase steps (22.5 degree units, 16 steps = 360)
	localparam logic [6:0] ADDR_BASE     = 7'h20;
	localparam logic [5:0] ADDR_STRAP_RES = 6'h03;
	localparam logic [4:0] PHASE_MAX     = 5'h10;
	localparam logic [4:0] PHASE_PER_ADDR = 5'h02;

	// Sequence strap groups (strap code / 3)
	localparam logic [2:0] GRP_FIRST = 3'h2;
	localparam logic [2:0] GRP_LAST  = 3'h3;
	localparam logic [2:0] GRP_MID   = 3'h4;
	localparam logic [2:0] GRP_TRACK = 3'h5;

	// Event bus frame
	localparam int EVT_BITS = 9;

	typedef enum logic [1:0] {SYNC_IN, SYNC_AUTO, SYNC_OUT} sync_dir_t;
	typedef enum logic [1:0] {ROLE_NONE, ROLE_FIRST, ROLE_MID, ROLE_LAST} seq_role_t;
	typedef enum logic [1:0] {EVT_ON, EVT_OFF, EVT_FAULT} evt_kind_t;

	typedef struct packed {
		sync_dir_t sync_dir;
		seq_role_t role;
		logic      track_en;
	} strap_cfg_t;

	typedef struct packed {
		evt_kind_t  kind;
		logic [6:0] addr;
	} evt_t;
endpackage
